// *** verilog/adc_control_interface.v ***
// control and status logic of an 8-bit successive approximation converter,
// with an apb register slave, event interrupt and low power mode handling
// assumes sys_clk at 20 MHz; comparator, mode and analog inputs are async
//
// Function
// - conversion end sets done flag bit6
// - request when done flag and enable bit7
// - writing zero never clears done flag
// - start bit5 begins conversion, clears flag
// - start during conversion restarts it fresh
// - start bit always reads back zero
// - power bit4 switches converter off/on
// - wait mode runs; done request wakes
// - bit2 drives main oscillator disable only
// - control register resets to 40h
// - result register eight bits, read only
//
// Implementation choice: the APB register port.
`timescale 1ns/1ns
`include "adc_ctrl_defs.vh"

module adc_control_interface #(
  parameter RES_W          = `RESULT_BITS,
  parameter CYCLES_PER_BIT = `CYCLES_PER_BIT
) (
  input  wire                 sys_clk,
  input  wire                 rst_b,
  // apb slave
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [`ADDR_W-1:0]   paddr,
  input  wire [31:0]          pwdata,
  input  wire [3:0]           pstrb,
  output reg  [31:0]          prdata,
  output reg                  pready,
  output reg                  pslverr,
  // analog front end
  input  wire                 compAbove,
  output reg  [RES_W-1:0]     dacCode,
  output reg                  converterPowerOn,
  output reg                  convBusy,
  // system
  input  wire                 waitMode,
  input  wire                 stopMode,
  output reg                  mainOscDisable,
  output reg                  convIrq,
  output reg                  waitWake,
  output reg                  eventIrq
);

  // --------------------------------------------------------------------------
  // local constants
  // --------------------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'b01;            // converter waiting
  localparam [1:0] ST_CONV = 2'b10;            // approximation running
  localparam [15:0] BIT_CNT_LAST = CYCLES_PER_BIT[15:0] - 16'h0001;
  localparam [2:0]  LAST_BIT    = RES_W[2:0] - 3'h1;

  // --------------------------------------------------------------------------
  // synchronisers for async inputs
  // --------------------------------------------------------------------------
  reg  [2:0] syncA_r;                          // first stage, read by second only
  reg  [2:0] syncB_r;                          // usable stage
  wire       compSync = syncB_r[0];            // comparator result
  wire       waitSync = syncB_r[1];            // cpu in wait mode
  wire       stopSync = syncB_r[2];            // cpu in stop mode

  // two flops per input; the first is never looked at elsewhere
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      syncA_r <= 3'h0;
      syncB_r <= 3'h0;
    end else begin
      syncA_r <= {stopMode, waitMode, compAbove};
      syncB_r <= syncA_r;
    end
  end

  // --------------------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------------------
  wire accessPhase = psel & penable & ~pready; // one wait state, then ready
  wire doneAccess  = psel & penable & pready;  // edge that completes a transfer
  wire hitResult   = (paddr == `ADDR_CONVERSION_RESULT);
  wire hitControl  = (paddr == `ADDR_CONVERTER_CONTROL);
  wire hitStatus   = (paddr == `ADDR_EVENT_STATUS);
  wire hitMask     = (paddr == `ADDR_EVENT_MASK);
  wire hitAny      = hitResult | hitControl | hitStatus | hitMask;
  wire lowLane     = pstrb[0];                 // all fields sit in byte lane 0
  wire wrControl   = doneAccess & pwrite & hitControl & lowLane;
  wire wrStatus    = doneAccess & pwrite & hitStatus & lowLane;
  wire wrMask      = doneAccess & pwrite & hitMask & lowLane;

  // --------------------------------------------------------------------------
  // control register state
  // --------------------------------------------------------------------------
  reg              irqEnable_r;                // interrupt enable, bit 7
  reg              convDone_r;                 // end of conversion, bit 6
  reg              powerOn_r;                  // converter power, bit 4
  reg              main_osc_disable_r;                   // main oscillator off, bit 2
  reg  [RES_W-1:0] result_r;                   // last completed result
  reg  [`EVT_W-1:0] evtStatus_r;               // sticky events
  reg  [`EVT_W-1:0] evtMask_r;                 // event enables

  wire startReq = wrControl & pwdata[`BIT_CONV_START];

  // converter may run only while powered and not in stop mode
  // power bit gates converter
  wire convAllowed = powerOn_r & ~stopSync;

  // --------------------------------------------------------------------------
  // approximation engine
  // --------------------------------------------------------------------------
  reg  [1:0]       state_r;
  reg  [1:0]       state_nxt;
  reg  [15:0]      bitCnt_r;                   // cycles spent on current bit
  reg  [15:0]      bitCnt_nxt;
  reg  [2:0]       bitIdx_r;                   // bit under trial, msb first
  reg  [2:0]       bitIdx_nxt;
  reg  [RES_W-1:0] sar_r;                      // approximation register
  reg  [RES_W-1:0] sar_nxt;
  reg              finish;                     // conversion completes now
  reg              abort;                      // running conversion dropped

  wire bitEnd = (bitCnt_r == BIT_CNT_LAST);

  // next state of the approximation; start always wins over completion
  always @* begin
    state_nxt  = state_r;
    bitCnt_nxt = bitCnt_r;
    bitIdx_nxt = bitIdx_r;
    sar_nxt    = sar_r;
    finish     = 1'b0;
    abort      = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (startReq && convAllowed) begin
          state_nxt  = ST_CONV;
          bitCnt_nxt = 16'h0000;
          bitIdx_nxt = LAST_BIT;
          sar_nxt    = {RES_W{1'b0}};
        end
      end
      ST_CONV: begin
        if (!convAllowed) begin
          // power removed or stop entered: drop the conversion
          state_nxt = ST_IDLE;
          abort     = 1'b1;
        end else if (startReq) begin
          bitCnt_nxt = 16'h0000;
          bitIdx_nxt = LAST_BIT;
          sar_nxt    = {RES_W{1'b0}};
          abort      = 1'b1;
        end else if (bitEnd) begin
          // keep the trial bit if the input is above the trial level
          sar_nxt[bitIdx_r] = compSync;
          bitCnt_nxt        = 16'h0000;
          if (bitIdx_r == 3'h0) begin
            state_nxt = ST_IDLE;
            finish    = 1'b1;
          end else begin
            bitIdx_nxt = bitIdx_r - 3'h1;
          end
        end else begin
          bitCnt_nxt = bitCnt_r + 16'h0001;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // sequencer registers
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r  <= ST_IDLE;
      bitCnt_r <= 16'h0000;
      bitIdx_r <= 3'h0;
      sar_r    <= {RES_W{1'b0}};
    end else begin
      state_r  <= state_nxt;
      bitCnt_r <= bitCnt_nxt;
      bitIdx_r <= bitIdx_nxt;
      sar_r    <= sar_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // result and flags
  // --------------------------------------------------------------------------
  // result is loaded only by a finished conversion
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      result_r <= `RESULT_RESET;
    end else if (finish) begin
      result_r <= sar_nxt;
    end
  end

  // end of conversion flag: set by hardware, cleared only by a start
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      convDone_r <= 1'b1;
    end else if (startReq) begin
      convDone_r <= 1'b0;
    end else if (finish) begin
      convDone_r <= 1'b1;
    end
  end

  // software writable control bits; reserved bits are not stored
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irqEnable_r <= 1'b0;
      powerOn_r   <= 1'b0;
      main_osc_disable_r    <= 1'b0;
    end else if (wrControl) begin
      irqEnable_r <= pwdata[`BIT_CONV_IRQ_ENABLE];
      powerOn_r   <= pwdata[`BIT_CONVERTER_POWER_ON];
      main_osc_disable_r    <= pwdata[`BIT_MAIN_OSC_DISABLE];
    end
  end

  // --------------------------------------------------------------------------
  // event status and mask; a new event beats a clear in the same cycle
  // --------------------------------------------------------------------------
  wire [`EVT_W-1:0] evtSet = {abort, finish};
  wire [`EVT_W-1:0] evtClr = wrStatus ? pwdata[`EVT_W-1:0] : {`EVT_W{1'b0}};

  genvar gi;
  generate
    for (gi = 0; gi < `EVT_W; gi = gi + 1) begin : gEvt
      // sticky bit, write one to clear
      always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          evtStatus_r[gi] <= 1'b0;
        end else if (evtSet[gi]) begin
          evtStatus_r[gi] <= 1'b1;
        end else if (evtClr[gi]) begin
          evtStatus_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // mask register
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      evtMask_r <= `EVT_RESET;
    end else if (wrMask) begin
      evtMask_r <= pwdata[`EVT_W-1:0];
    end
  end

  // --------------------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------------------
  reg [31:0] rdMux;

  // start and reserved bits read zero
  always @* begin
    rdMux = 32'h0000_0000;
    if (hitResult) begin
      rdMux[RES_W-1:0] = result_r;
    end else if (hitControl) begin
      rdMux[`BIT_CONV_IRQ_ENABLE]    = irqEnable_r;
      rdMux[`BIT_CONV_DONE]          = convDone_r;
      rdMux[`BIT_CONVERTER_POWER_ON] = powerOn_r;
      rdMux[`BIT_MAIN_OSC_DISABLE]   = main_osc_disable_r;
    end else if (hitStatus) begin
      rdMux[`EVT_W-1:0] = evtStatus_r;
    end else if (hitMask) begin
      rdMux[`EVT_W-1:0] = evtMask_r;
    end
  end

  // apb answer: ready one cycle into the access phase
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= accessPhase;
      pslverr <= accessPhase & ~hitAny;
      prdata  <= (accessPhase & ~pwrite) ? rdMux : 32'h0000_0000;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  // registered copies of internal state; requests computed from current register values
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dacCode          <= {RES_W{1'b0}};
      converterPowerOn <= 1'b0;
      convBusy         <= 1'b0;
      mainOscDisable   <= 1'b0;
      convIrq          <= 1'b0;
      waitWake         <= 1'b0;
      eventIrq         <= 1'b0;
    end else begin
      // trial code: settled bits plus the one under test
      dacCode          <= (state_r == ST_CONV) ? (sar_r | ({{(RES_W-1){1'b0}}, 1'b1} << bitIdx_r))
                                              : result_r;
      converterPowerOn <= convAllowed;
      convBusy         <= (state_r == ST_CONV);
      mainOscDisable   <= main_osc_disable_r;
      convIrq          <= convDone_r & irqEnable_r;
      waitWake         <= convDone_r & irqEnable_r & waitSync & ~stopSync;
      eventIrq         <= |(evtStatus_r & evtMask_r);
    end
  end

endmodule

// *** verilog/adc_ctrl_defs.vh ***
// constants for the converter control block: register indices, bit positions,
// reset values and conversion timing
// assumes a 32-bit apb bus with one register per aligned word
`ifndef ADC_CTRL_DEFS_VH
`define ADC_CTRL_DEFS_VH

// ----------------------------------------------------------------------------
// register indices; byte address is four times the index
// ----------------------------------------------------------------------------
`define IDX_CONVERSION_RESULT   8'hd0
`define IDX_CONVERTER_CONTROL   8'hd1
`define IDX_EVENT_STATUS        8'he0
`define IDX_EVENT_MASK          8'he1
`define ADDR_W                  12
`define ADDR_CONVERSION_RESULT  12'h340
`define ADDR_CONVERTER_CONTROL  12'h344
`define ADDR_EVENT_STATUS       12'h380
`define ADDR_EVENT_MASK         12'h384

// ----------------------------------------------------------------------------
// converter_control fields
// ----------------------------------------------------------------------------
`define BIT_CONV_IRQ_ENABLE     7
`define BIT_CONV_DONE           6
`define BIT_CONV_START          5
`define BIT_CONVERTER_POWER_ON  4
`define BIT_RESERVED_BIT_THREE  3
`define BIT_MAIN_OSC_DISABLE    2
`define CONTROL_RESET           8'h40
`define RESULT_RESET            8'h00

// ----------------------------------------------------------------------------
// event status / mask fields
// ----------------------------------------------------------------------------
`define EVT_W                   2
`define EVT_DONE                0
`define EVT_ABORT               1
`define EVT_RESET               2'h0

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CONV_TIME_NS            70000
`define CLK_PERIOD_NS           50
`define RESULT_BITS             8
`define CONV_CYCLES             (`CONV_TIME_NS / `CLK_PERIOD_NS)
`define CYCLES_PER_BIT          (`CONV_CYCLES / `RESULT_BITS)

`endif

// *** sim/adc_control_interface_assertions.sv ***
// port checker of the converter control block
// assumes bind into adc_control_interface, one clock domain
`timescale 1ns/1ns
`include "adc_ctrl_defs.vh"

module adc_control_interface_assertions (
  input wire               sys_clk,
  input wire               rst_b,
  input wire               psel,
  input wire               penable,
  input wire               pwrite,
  input wire [`ADDR_W-1:0] paddr,
  input wire [31:0]        pwdata,
  input wire [3:0]         pstrb,
  input wire [31:0]        prdata,
  input wire               pready,
  input wire               convBusy,
  input wire               stopMode,
  input wire               converterPowerOn,
  input wire               waitWake,
  input wire               convIrq,
  input wire               mainOscDisable,
  input wire               eventIrq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ---------------------------------------------------------------
  // completed control write, byte 0 enabled
  // ---------------------------------------------------------------
  wire ctlWr = psel && penable && pready && pwrite && pstrb[0] && paddr == `ADDR_CONVERTER_CONTROL;
  a_start_reads_zero: assert property (pready && !pwrite && paddr == `ADDR_CONVERTER_CONTROL
    |-> prdata[5] == 1'b0)
    else $error("start bit read back as one");
  a_upper_bits_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_osc_follows: assert property (ctlWr |=> ##1 mainOscDisable == $past(pwdata[2], 2))
    else $error("oscillator disable not following bit two");
  a_power_follows: assert property (ctlWr && !stopMode |=> ##1 converterPowerOn == $past(pwdata[4], 2))
    else $error("power output not following bit four");
  a_irq_off_write: assert property (ctlWr && (!pwdata[7] || pwdata[5]) |=> ##1 !convIrq)
    else $error("request kept after disable or start");
  a_busy_after_start: assert property (ctlWr && pwdata[5] && converterPowerOn && !stopMode |=> ##1 convBusy)
    else $error("no conversion after start");
  a_irq_drop_write: assert property ($fell(convIrq) |-> $past(pready && pwrite, 2))
    else $error("request dropped without a write");
  a_stop_power_off: assert property (stopMode [*5] |-> !converterPowerOn)
    else $error("converter powered in stop");
  a_stop_no_wake: assert property (stopMode [*5] |-> !waitWake)
    else $error("wake raised in stop");
  a_wake_needs_irq: assert property (waitWake |-> convIrq)
    else $error("wake without request");
  // main scenarios reached
  c_irq: cover property ($rose(convIrq));
  c_wake: cover property ($rose(waitWake));
  c_event: cover property ($rose(eventIrq));
endmodule

bind adc_control_interface adc_control_interface_assertions u_adc_control_interface_assertions (
  .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .convBusy(convBusy),
  .stopMode(stopMode), .converterPowerOn(converterPowerOn), .waitWake(waitWake), .convIrq(convIrq),
  .mainOscDisable(mainOscDisable), .eventIrq(eventIrq));

// *** sim/testbench.sv ***
// self-checking bench of the converter control block
// assumes an apb slave with registered ready and a bit time cut to 4 cycles
`timescale 1ns/1ns
`include "adc_ctrl_defs.vh"

module testbench;
  // ---------------------------------------------------------------
  // nets
  // ---------------------------------------------------------------
  localparam [`ADDR_W-1:0] CTL = `ADDR_CONVERTER_CONTROL;
  localparam [`ADDR_W-1:0] RES = `ADDR_CONVERSION_RESULT;
  localparam [`ADDR_W-1:0] STS = `ADDR_EVENT_STATUS;
  localparam [`ADDR_W-1:0] MSK = `ADDR_EVENT_MASK;
  reg                sys_clk = 1'b0;
  reg                rst_b = 1'b0;
  reg                psel = 1'b0;
  reg                penable = 1'b0;
  reg                pwrite = 1'b0;
  reg  [`ADDR_W-1:0] paddr = 12'h000;
  reg  [31:0]        pwdata = 32'h0;
  reg  [3:0]         pstrb = 4'hf;
  reg                compAbove = 1'b1;
  reg                waitMode = 1'b0;
  reg                stopMode = 1'b0;
  wire [31:0]        prdata;
  wire               pready;
  wire               pslverr;
  wire [7:0]         dacCode;
  wire               converterPowerOn;
  wire               convBusy;
  wire               mainOscDisable;
  wire               convIrq;
  wire               waitWake;
  wire               eventIrq;
  reg  [31:0]        rdat;
  reg                rerr;
  int                fails = 0;
  int                comparisons = 0;

  adc_control_interface #(.CYCLES_PER_BIT(4)) u_adc_control_interface (
    .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .compAbove(compAbove), .dacCode(dacCode), .converterPowerOn(converterPowerOn), .convBusy(convBusy),
    .waitMode(waitMode), .stopMode(stopMode), .mainOscDisable(mainOscDisable), .convIrq(convIrq),
    .waitWake(waitWake), .eventIrq(eventIrq));

  // 50 ns period
  always #25 sys_clk = ~sys_clk;

  // ---------------------------------------------------------------
  // bus and compare helpers
  // ---------------------------------------------------------------
  // one apb transfer; answer taken at the rising edge that samples pready high
  task automatic xfer(input reg w, input reg [`ADDR_W-1:0] a, input reg [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rdat = prdata;
    rerr = pslverr;
    if (n >= 40) begin
      fails++;
      $display("Error pready expected 1 seen %b", pready);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input reg [31:0] e, input reg [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdchk(input reg [`ADDR_W-1:0] a, input reg [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk("read data", e, rdat);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // poll the done flag under a bound
  task automatic waitDone;
    int n;
    n = 0;
    rdat = 32'h0;
    while (rdat[6] !== 1'b1 && n < 30) begin
      xfer(1'b0, CTL, 32'h0);
      n++;
    end
    chk("done flag", 32'h1, {31'h0, rdat[6]});
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic tReset;
    rdchk(CTL, 32'h40);
    rdchk(RES, 32'h0);
    rdchk(STS, 32'h0);
  endtask
  // full conversion, flag and request handling
  task automatic tConvert;
    xfer(1'b1, CTL, 32'h10);
    xfer(1'b1, CTL, 32'h30);
    rdchk(CTL, 32'h10);
    waitDone;
    rdchk(RES, 32'hff);
    chk("dacCode", 32'hff, {24'h0, dacCode});
    xfer(1'b1, RES, 32'h55);
    rdchk(RES, 32'hff);
    xfer(1'b1, CTL, 32'h90);
    rdchk(CTL, 32'hd0);
    tick(3);
    chk("convIrq", 32'h1, {31'h0, convIrq});
    xfer(1'b1, CTL, 32'h10);
    tick(3);
    chk("convIrq", 32'h0, {31'h0, convIrq});
  endtask
  // aborts by power off and by restart, event interrupt
  task automatic tAbort;
    xfer(1'b1, MSK, 32'h3);
    compAbove <= 1'b0;
    xfer(1'b1, CTL, 32'h30);
    tick(8);
    chk("dacCode", 32'h40, {24'h0, dacCode});
    xfer(1'b1, CTL, 32'h0);
    tick(40);
    rdchk(CTL, 32'h0);
    rdchk(RES, 32'hff);
    xfer(1'b1, STS, 32'h3);
    xfer(1'b1, CTL, 32'h10);
    xfer(1'b1, CTL, 32'h30);
    tick(8);
    xfer(1'b1, CTL, 32'h30);
    rdchk(STS, 32'h2);
    chk("eventIrq", 32'h1, {31'h0, eventIrq});
    xfer(1'b1, STS, 32'h2);
    tick(12);
    rdchk(CTL, 32'h10);
    waitDone;
    rdchk(RES, 32'h0);
    rdchk(STS, 32'h1);
    chk("eventIrq", 32'h1, {31'h0, eventIrq});
    xfer(1'b1, MSK, 32'h0);
    tick(3);
    chk("eventIrq", 32'h0, {31'h0, eventIrq});
    xfer(1'b1, STS, 32'h1);
    rdchk(STS, 32'h0);
  endtask
  // wait, stop, oscillator bit, refused accesses
  task automatic tModes;
    xfer(1'b1, CTL, 32'h94);
    waitMode <= 1'b1;
    tick(5);
    rdchk(CTL, 32'hd4);
    chk("mainOscDisable", 32'h1, {31'h0, mainOscDisable});
    chk("converterPowerOn", 32'h1, {31'h0, converterPowerOn});
    chk("waitWake", 32'h1, {31'h0, waitWake});
    stopMode <= 1'b1;
    tick(6);
    chk("converterPowerOn", 32'h0, {31'h0, converterPowerOn});
    chk("waitWake", 32'h0, {31'h0, waitWake});
    xfer(1'b1, CTL, 32'h34);
    tick(4);
    chk("convBusy", 32'h0, {31'h0, convBusy});
    rdchk(CTL, 32'h14);
    stopMode <= 1'b0;
    waitMode <= 1'b0;
    tick(6);
    rdchk(12'h100, 32'h0);
    chk("pslverr", 32'h1, {31'h0, rerr});
    pstrb <= 4'h0;
    xfer(1'b1, CTL, 32'h0);
    pstrb <= 4'hf;
    rdchk(CTL, 32'h14);
  endtask

  // ---------------------------------------------------------------
  // sequence, watchdog and verdict
  // ---------------------------------------------------------------
  task automatic results;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    tReset;
    tConvert;
    tAbort;
    tModes;
    results;
  end
  // hang guard, far beyond the few hundred cycles needed
  initial begin
    #1000000;
    fails++;
    results;
  end
endmodule
